/* File: st56_pkg.sv */
/*
 * Constants of the 56-bit system timer: register offsets, field positions,
 * reset values and widths.
 * Assumes an APB slave with byte addresses and one 32-bit word per register.
 */
package st56_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 56;
    localparam int NCMP   = 2;

    // register byte offsets
    localparam logic [7:0] OFF_CLC    = 8'h00;
    localparam logic [7:0] OFF_RSTREQ = 8'h04;
    localparam logic [7:0] OFF_CMPCFG = 8'h08;
    localparam logic [7:0] OFF_TIM0   = 8'h10;
    localparam logic [7:0] OFF_TIM6   = 8'h28;
    localparam logic [7:0] OFF_CAP    = 8'h2c;
    localparam logic [7:0] OFF_CMP0   = 8'h30;
    localparam logic [7:0] OFF_CMP1   = 8'h34;
    localparam logic [7:0] OFF_STATUS = 8'h38;
    localparam logic [7:0] OFF_MASK   = 8'h3c;

    // timer_clock_control_reg fields
    localparam int CLC_DIS_BIT     = 0;
    localparam int CLC_DIS_ST_BIT  = 1;
    localparam int CLC_SUSP_EN_BIT = 3;
    localparam int CLC_SUSP_ST_BIT = 4;
    localparam int CLC_DIV_LSB     = 8;
    localparam int DIV_W           = 3;
    localparam logic [2:0] CLC_DIV_RST = 3'h2;

    // soft reset request register: bit of timer_soft_reset_request
    localparam int RSTREQ_TIMER_BIT = 0;

    // compare configuration: per compare a size field and a start field
    localparam int CMPCFG_SIZE_LSB  = 0;
    localparam int CMPCFG_START_LSB = 8;
    localparam int CMPCFG_STRIDE    = 16;
    localparam int CMP_FLD_W        = 5;
    localparam logic [31:0] CMPCFG_RST = 32'h001f_001f;

    // section read layout
    localparam int TIM_STEP     = 4;
    localparam int TIM_LAST     = 6;
    localparam int TIM_CAP_LAST = 5;
    localparam int CAP_LSB      = 32;
    localparam int CAP_W        = 24;

endpackage

/* File: st56_timer.sv */
/*
 * Free-running 56-bit system timer with APB register access, section read
 * windows, upper-part capture, two partial compares and one interrupt.
 * Assumes pclk drives all logic; watchdog and soft reset pulses come from the
 * reset unit on pclk; the hardware reset pin and debug suspend are pins.
 */
// Function
// [R1] 56-bit counter increments by one on every divided timer tick.
// [R2] tick rate is pclk divided by 3-bit setting, default 010.
// [R3] power-on, watchdog, enabled soft reset clear, enable and restart timer.
// [R4] hardware reset pin leaves count and divider setting untouched.
// [R5] count registers are read-only; writes to them are ignored.
// [R6] reading section registers 0..5 latches upper count into capture register.
// [R7] seven section registers: 0..5 are 32-bit slices, section 6 a 24-bit slice, rising in order.
// [R8] two compare values against selectable count slice raise interrupts.
// [R9] clock control can disable or debug-suspend the timer; reads still work.
// [R10] sections 0..5 start at bits 0,4,..,20; section 6 is bits 55:32.
// [R11] software reads a low section, then capture, for a consistent count.
module st56_timer
    import st56_pkg::*;
(
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [st56_pkg::ADDR_W-1:0] paddr,
    input  wire logic [st56_pkg::DATA_W-1:0] pwdata,
    output logic      [st56_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        hardware_reset_pin_n,
    input  wire logic                        wdt_reset,
    input  wire logic                        soft_reset,
    input  wire logic                        debug_suspend,
    output logic                             irq
);
    import st56_pkg::*;

    function automatic logic [31:0] tim_slice(input logic [CNT_W-1:0] cnt,
                                              input logic [2:0]       k);
        logic [CNT_W-1:0] sh;
        sh = cnt >> (k * TIM_STEP);
        if (k == 3'(TIM_LAST)) begin
            sh = cnt >> CAP_LSB;
        end
        return sh[31:0];
    endfunction

    function automatic logic cmp_hit(input logic [CNT_W-1:0]     cnt,
                                     input logic [31:0]          val,
                                     input logic [CMP_FLD_W-1:0] start,
                                     input logic [CMP_FLD_W-1:0] size);
        logic [CNT_W-1:0] sh;
        logic [31:0]      m;
        sh = cnt >> start;
        m  = 32'hffff_ffff >> (5'h1f - size);
        return ((sh[31:0] ^ val) & m) == 32'h0000_0000;
    endfunction

    // pin synchronisers
    logic [1:0] hrst_sync_r;
    logic [1:0] susp_sync_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hrst_sync_r <= 2'b11;
            susp_sync_r <= 2'b00;
        end else begin
            hrst_sync_r <= {hrst_sync_r[0], hardware_reset_pin_n};
            susp_sync_r <= {susp_sync_r[0], debug_suspend};
        end
    end

    wire hw_rst    = !hrst_sync_r[1];
    wire susp_pin  = susp_sync_r[1];

    // state
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [DIV_W-1:0] presc_r;
    logic [DIV_W-1:0] presc_nxt;
    logic [DIV_W-1:0] div_r;
    logic             dis_r;
    logic             susp_en_r;
    logic             rstreq_r;
    logic [CAP_W-1:0] cap_r;
    logic [31:0]      cmp_r [NCMP];
    logic [31:0]      cmpcfg_r;
    logic [NCMP-1:0]  match_prev_r;
    logic [NCMP-1:0]  status_r;
    logic [NCMP-1:0]  status_nxt;
    logic [NCMP-1:0]  mask_r;
    logic [31:0]      prdata_r;
    logic             err_r;

    // register decode
    wire setup_ph   = psel & !penable;
    wire access_ph  = psel & penable;
    wire aligned    = paddr[1:0] == 2'b00;
    wire hit_clc    = paddr == OFF_CLC;
    wire hit_rstreq = paddr == OFF_RSTREQ;
    wire hit_cmpcfg = paddr == OFF_CMPCFG;
    wire hit_tim    = aligned & (paddr >= OFF_TIM0) & (paddr <= OFF_TIM6);
    wire hit_cap    = paddr == OFF_CAP;
    wire hit_cmp0   = paddr == OFF_CMP0;
    wire hit_cmp1   = paddr == OFF_CMP1;
    wire hit_status = paddr == OFF_STATUS;
    wire hit_mask   = paddr == OFF_MASK;
    wire mapped     = hit_clc | hit_rstreq | hit_cmpcfg | hit_tim | hit_cap
                    | hit_cmp0 | hit_cmp1 | hit_status | hit_mask;
    wire [7:0] tim_off = paddr - OFF_TIM0;
    wire [2:0] tim_k   = tim_off[4:2];

    wire wr_ok     = access_ph & pwrite & mapped;
    wire rd_setup  = setup_ph & !pwrite;
    // capture at the same edge the section value is sampled for prdata
    wire cap_load  = rd_setup & hit_tim & (tim_k <= 3'(TIM_CAP_LAST)); // [R6]

    // reset sources of the timer itself
    wire timer_rst = wdt_reset | (soft_reset & rstreq_r); // [R3]

    // tick generation
    wire [DIV_W-1:0] div_eff = (div_r == 3'h0) ? 3'h1 : div_r;
    wire             halted  = susp_en_r & susp_pin; // [R9]
    wire             run     = !dis_r & !halted; // [R9]
    wire             tick    = run & (presc_r >= div_eff - 3'h1); // [R2]

    always_comb begin
        presc_nxt = presc_r;
        count_nxt = count_r;
        if (tick) begin
            presc_nxt = 3'h0;
            count_nxt = count_r + 56'h1; // [R1]
        end else if (run) begin
            presc_nxt = presc_r + 3'h1; // [R2]
        end
    end

    // count, prescaler and divider: cleared by presetn and timer resets only,
    // never by the hardware reset pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= '0; // [R3]
            presc_r <= 3'h0;
            div_r   <= CLC_DIV_RST; // [R2]
            dis_r   <= 1'b0;
        end else if (timer_rst) begin
            count_r <= '0; // [R3]
            presc_r <= 3'h0;
            div_r   <= CLC_DIV_RST;
            dis_r   <= 1'b0; // [R3]
        end else begin
            count_r <= count_nxt; // [R4]
            presc_r <= presc_nxt;
            if (wr_ok & hit_clc) begin
                div_r <= pwdata[CLC_DIV_LSB +: DIV_W]; // [R4]
                dis_r <= pwdata[CLC_DIS_BIT];
            end
        end
    end

    // software-side control, also cleared by the hardware reset pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            susp_en_r <= 1'b0;
            rstreq_r  <= 1'b0;
            cmpcfg_r  <= CMPCFG_RST;
            cmp_r[0]  <= 32'h0000_0000;
            cmp_r[1]  <= 32'h0000_0000;
            mask_r    <= '0;
        end else if (hw_rst) begin
            susp_en_r <= 1'b0;
            rstreq_r  <= 1'b0;
            cmpcfg_r  <= CMPCFG_RST;
            cmp_r[0]  <= 32'h0000_0000;
            cmp_r[1]  <= 32'h0000_0000;
            mask_r    <= '0;
        end else if (wr_ok) begin
            if (hit_clc) begin
                susp_en_r <= pwdata[CLC_SUSP_EN_BIT];
            end
            if (hit_rstreq) begin
                rstreq_r <= pwdata[RSTREQ_TIMER_BIT];
            end
            if (hit_cmpcfg) begin
                cmpcfg_r <= pwdata;
            end
            if (hit_cmp0) begin
                cmp_r[0] <= pwdata;
            end
            if (hit_cmp1) begin
                cmp_r[1] <= pwdata;
            end
            if (hit_mask) begin
                mask_r <= pwdata[NCMP-1:0];
            end
        end
    end

    // compare: an event is the first cycle of a match, so a count that
    // stays on the value (timer halted) raises only one event
    logic [NCMP-1:0] match_now;
    logic [NCMP-1:0] match_ev;

    always_comb begin
        for (int i = 0; i < NCMP; i++) begin
            match_now[i] = cmp_hit(count_r, cmp_r[i],
                cmpcfg_r[i*CMPCFG_STRIDE + CMPCFG_START_LSB +: CMP_FLD_W],
                cmpcfg_r[i*CMPCFG_STRIDE + CMPCFG_SIZE_LSB +: CMP_FLD_W]); // [R8]
        end
        match_ev = match_now & ~match_prev_r; // [R8]
    end

    wire [NCMP-1:0] st_clr = (wr_ok & hit_status) ? pwdata[NCMP-1:0] : '0;

    // a new event wins over a write-one clear in the same cycle
    assign status_nxt = (status_r & ~st_clr) | match_ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_prev_r <= '0;
            status_r     <= '0;
        end else if (hw_rst) begin
            match_prev_r <= match_now;
            status_r     <= '0;
        end else begin
            match_prev_r <= match_now;
            status_r     <= status_nxt; // [R8]
        end
    end

    assign irq = |(status_r & mask_r); // [R8]

    // capture register keeps its value across the hardware reset pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_r <= '0;
        end else if (cap_load) begin
            cap_r <= count_r[CAP_LSB +: CAP_W]; // [R6]
        end
    end

    // read mux
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_clc) begin
            rd_mux[CLC_DIS_BIT]                = dis_r;
            rd_mux[CLC_DIS_ST_BIT]             = dis_r;
            rd_mux[CLC_SUSP_EN_BIT]            = susp_en_r;
            rd_mux[CLC_SUSP_ST_BIT]            = halted;
            rd_mux[CLC_DIV_LSB +: DIV_W]       = div_r;
        end else if (hit_rstreq) begin
            rd_mux[RSTREQ_TIMER_BIT] = rstreq_r;
        end else if (hit_cmpcfg) begin
            rd_mux = cmpcfg_r;
        end else if (hit_tim) begin
            rd_mux = tim_slice(count_r, tim_k); // [R7] [R10]
        end else if (hit_cap) begin
            rd_mux[CAP_W-1:0] = cap_r;
        end else if (hit_cmp0) begin
            rd_mux = cmp_r[0];
        end else if (hit_cmp1) begin
            rd_mux = cmp_r[1];
        end else if (hit_status) begin
            rd_mux[NCMP-1:0] = status_r;
        end else if (hit_mask) begin
            rd_mux[NCMP-1:0] = mask_r;
        end
    end

    // apb answer: data and error sampled in setup, shown in the access cycle;
    // writes to section and capture registers are accepted but store nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            err_r    <= 1'b0;
        end else if (setup_ph) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_mux; // [R5]
            err_r    <= !mapped;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = access_ph;
    assign pslverr = access_ph & err_r;

endmodule

/* File: st56_cpu_model.sv */
/* apb master standing in for the cpu that reads and sets up the timer.
   assumes one pclk and a slave that answers through pready. */
module st56_cpu_model (
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // called just after a rising edge; ends one idle edge later so strobes never toggle twice at once
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

/* File: st56_timer_sva.sv */
/* checker of the system timer port behaviour.
   assumes a single pclk domain and the presetn reset. */
module st56_timer_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        hardware_reset_pin_n,
    input wire logic        wdt_reset,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import st56_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable;
    wire logic setup_rd = psel && !penable && !pwrite;
    chk_ready_acc: assert property (acc |-> pready) else $error("pready low in access");
    chk_ready_idle: assert property (!acc |-> !pready && !pslverr) else $error("answer outside access");
    chk_unmapped_err: assert property (setup_rd && paddr == 8'h0c ##1 acc |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    chk_ro_no_err: assert property (acc && pwrite && paddr >= OFF_TIM0 && paddr <= OFF_CAP |-> !pslverr)
        else $error("count write flagged");
    chk_top_zero: assert property (setup_rd && paddr == OFF_TIM6 |=> prdata[31:24] == 8'h0)
        else $error("top section not zero extended");
    chk_rd_hold: assert property (acc && !pwrite ##1 !psel |-> $stable(prdata)) else $error("read data moved");
    chk_mask_off: assert property (acc && pwrite && paddr == OFF_MASK && pwdata == 32'h0 |=> !irq)
        else $error("irq with mask clear");
    chk_wdt_clear: assert property (wdt_reset ##1 setup_rd && paddr == OFF_TIM0 |=> prdata < 32'h2)
        else $error("count not cleared");
    chk_pin_irq: assert property (!hardware_reset_pin_n [*4] |-> !irq) else $error("irq during pin reset");
endmodule

bind st56_timer st56_timer_chk st56_timer_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .hardware_reset_pin_n, .wdt_reset, .irq);

/* File: test_system_timer_56bit.sv */
/* self-checking bench of the 56-bit system timer.
   assumes the cpu model drives apb and the checker is bound to the timer. */
module test_system_timer_56bit import st56_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic hardware_reset_pin_n, wdt_reset, soft_reset, debug_suspend;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, a;
    int          err_total = 0;
    int          num_checks = 0;
    int          dv[4] = '{0, 1, 2, 7};
    st56_timer st56_timer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .hardware_reset_pin_n, .wdt_reset, .soft_reset, .debug_suspend, .irq);
    st56_cpu_model st56_cpu_model_inst (.psel, .penable, .pwrite, .paddr, .pwdata, .pclk, .prdata, .pready, .pslverr);
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic wr(logic [7:0] ad, logic [31:0] d);
        st56_cpu_model_inst.xfer(1'b1, ad, d, rd, e);
    endtask
    task automatic rg(logic [7:0] ad);
        st56_cpu_model_inst.xfer(1'b0, ad, 32'h0, rd, e);
    endtask
    task automatic pulse(ref logic s);
        s <= 1'b1;
        @(posedge pclk);
        s <= 1'b0;
    endtask
    task automatic t_reset;
        rg(OFF_CLC); chk("clc", 32'h200, rd);
        rg(OFF_CMPCFG); chk("cmpcfg", CMPCFG_RST, rd);
        rg(8'h0c); chk("unmapped", 32'h1, {rd[30:0], e});
        $display("reset values done");
    endtask
    task automatic t_rate;
        // interval between samples is a whole number of ticks, so the step is exact
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CLC, 32'(dv[i]) << 8);
            rg(OFF_TIM0); a = rd;
            repeat ((dv[i] < 2) ? 0 : dv[i] - 1) rg(OFF_CLC);
            rg(OFF_TIM0); chk("tick step", a + 32'd3, rd);
        end
        $display("tick rate done");
    endtask
    task automatic t_hold;
        wr(OFF_CLC, 32'h201);
        rg(OFF_CLC); chk("disabled", 32'h203, rd);
        rg(OFF_TIM0); a = rd;
        wr(OFF_TIM0, 32'hffff_ffff); chk("ro write", 32'h0, {31'h0, e});
        for (int k = 0; k < 6; k++) begin
            rg(OFF_TIM0 + 8'(4 * k)); chk("section", a >> (4 * k), rd);
        end
        rg(OFF_TIM6); chk("top section", 32'h0, rd);
        rg(OFF_CAP); chk("capture", 32'h0, rd);
        $display("sections done");
    endtask
    task automatic t_susp;
        wr(OFF_CLC, 32'h208);
        debug_suspend <= 1'b1;
        repeat (4) @(posedge pclk);
        rg(OFF_CLC); chk("suspended", 32'h218, rd);
        rg(OFF_TIM0); a = rd;
        repeat (6) @(posedge pclk);
        rg(OFF_TIM0); chk("halted", a, rd);
        debug_suspend <= 1'b0;
        $display("suspend done");
    endtask
    task automatic t_cmp;
        int n;
        wr(OFF_CLC, 32'h100);
        wr(OFF_CMPCFG, 32'h001f_0403); // unit 0 watches count bits 7:4 only
        wr(OFF_CMP0, 32'ha);
        rg(OFF_TIM0); wr(OFF_CMP1, rd + 32'd40);
        // matches of the reset-time compare values leave stale bits; start clean
        wr(OFF_STATUS, 32'h3);
        wr(OFF_MASK, 32'h1);
        for (n = 0; n < 600 && irq !== 1'b1; n++) @(posedge pclk);
        #1 chk("irq", 32'h1, {31'h0, irq});
        repeat (60) @(posedge pclk);
        rg(OFF_STATUS); chk("status", 32'h3, rd);
        wr(OFF_MASK, 32'h0);
        #1 chk("mask clear", 32'h0, {31'h0, irq});
        @(posedge pclk);
        wr(OFF_STATUS, 32'h2);
        rg(OFF_STATUS); chk("w1c", 32'h1, rd);
        wr(OFF_MASK, 32'h2);
        #1 chk("masked", 32'h0, {31'h0, irq});
        @(posedge pclk);
        $display("compare done");
    endtask
    task automatic t_rst;
        wr(OFF_CLC, 32'h500);
        hardware_reset_pin_n <= 1'b0;
        repeat (4) @(posedge pclk);
        hardware_reset_pin_n <= 1'b1;
        repeat (3) @(posedge pclk);
        rg(OFF_CLC); chk("div kept", 32'h500, rd);
        rg(OFF_TIM0); chk("count kept", 32'h1, {31'h0, rd > 32'd100}); a = rd;
        wr(OFF_RSTREQ, 32'h0); pulse(soft_reset);
        rg(OFF_TIM0); chk("no soft clear", 32'h1, {31'h0, rd > a});
        wr(OFF_RSTREQ, 32'h1); pulse(soft_reset);
        rg(OFF_TIM0); chk("soft clear", 32'h1, {31'h0, rd < 32'd4});
        rg(OFF_CLC); chk("clc restored", 32'h200, rd);
        wr(OFF_CLC, 32'h501); pulse(wdt_reset);
        rg(OFF_TIM0); chk("wdt clear", 32'h1, {31'h0, rd < 32'd4});
        rg(OFF_CLC); chk("wdt enable", 32'h200, rd);
        $display("resets done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        hardware_reset_pin_n = 1'b1;
        wdt_reset = 1'b0;
        soft_reset = 1'b0;
        debug_suspend = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_rate;
        t_hold;
        t_susp;
        t_cmp;
        t_rst;
        finish_test;
    end
    initial begin
        #500000;
        err_total++;
        finish_test;
    end
endmodule
